/* src/csp_clock_ctrl.sv */
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module csp_clock_ctrl
   import csp_pkg::*;
(
   input  wire logic          core_clk,
   input  wire logic          resetn,
   input  wire logic [3:0]    reg_addr,
   input  wire logic [15:0]   reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic [15:0]        reg_rdata,
   input  wire logic          switch_monitor_config,
   input  wire logic [2:0]    initial_source_config,
   input  wire logic [1:0]    primary_submode_config,
   input  wire logic          low_power_crystal_keep,
   input  wire logic          watchdog_enable,
   input  wire csp_osc_stat_s osc_stat,
   input  wire logic          new_clk_tick,
   input  wire logic          psave_exec,
   input  wire logic [1:0]    psave_operand,
   input  wire logic          irq_pending,
   input  wire logic          wdt_timeout,
   output csp_osc_en_s        osc_en,
   output logic [2:0]         sys_src_sel,
   output logic [1:0]         primary_submode,
   output logic               fail_trap,
   output logic               watchdog_clear,
   output logic               cpu_clk_en,
   output logic               periph_clk_en,
   output logic               sys_clk_en
);

   ////////////////////////////////////////////////////////////////////////////
   // Stat synchronisers and basic state

   csp_osc_stat_s stat_s1;
   csp_osc_stat_s stat;
   logic          tick_s1;
   logic          tick_s2;
   logic          tick_s3;
   logic          new_tick;
   logic          sw_enabled;
   logic [2:0]    current_source_status;
   logic [2:0]    next_source_select;
   logic          switch_request;
   logic          clock_fail_flag;
   logic          lock_flag;
   logic          hi_open;
   logic          lo_open;
   logic          wr_ctrl;
   logic          wr_key;
   logic          switching;
   logic          count_start;
   logic          count_done;
   logic          src_ready;
   logic          in_sleep;
   logic          in_idle;
   logic          entering;
   logic          entry_mode;
   logic          held_irq;
   logic          wake_event;
   logic [2:0]    wake_cnt;
   logic          fail_seen;
   logic          armed;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         stat_s1 <= '0;
         stat    <= '0;
         tick_s1 <= 1'b0;
         tick_s2 <= 1'b0;
         tick_s3 <= 1'b0;
      end else begin
         stat_s1 <= osc_stat;
         stat    <= stat_s1;
         tick_s1 <= new_clk_tick;
         tick_s2 <= tick_s1;
         tick_s3 <= tick_s2;
      end
   end

   assign new_tick   = tick_s2 && !tick_s3;
   assign sw_enabled = !switch_monitor_config;
   assign primary_submode = primary_submode_config;
   assign wr_ctrl    = reg_wr && (reg_addr == REG_OSC_CTRL);
   assign wr_key     = reg_wr && (reg_addr == REG_OSC_KEY);

   ////////////////////////////////////////////////////////////////////////////
   // Unlock sequences for the two control bytes

   csp_unlock u_hi (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .key_wr     (wr_key),
      .key_data   (reg_wdata),
      .consume    (wr_ctrl),
      .key_first  (KEY_HI_1),
      .key_second (KEY_HI_2),
      .open       (hi_open)
   );

   csp_unlock u_lo (
      .core_clk   (core_clk),
      .resetn     (resetn),
      .key_wr     (wr_key),
      .key_data   (reg_wdata),
      .consume    (wr_ctrl),
      .key_first  (KEY_LO_1),
      .key_second (KEY_LO_2),
      .open       (lo_open)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Switch sequence

   assign src_ready = csp_uses_pll(next_source_select) ? stat.pll_lock :
                      (next_source_select == SRC_LPXTAL) ? stat.lpxtal_ready :
                      csp_is_crystal(next_source_select) ? stat.pri_ready : 1'b1;

   csp_new_clk_count u_cnt (
      .core_clk     (core_clk),
      .resetn       (resetn),
      .start        (count_start),
      .new_clk_tick (new_tick),
      .done         (count_done)
   );

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         next_source_select <= SRC_FRC;
      end else if (wr_ctrl && hi_open && sw_enabled) begin
         next_source_select <= reg_wdata[NEXT_LSB +: 3];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         switch_request <= 1'b0;
         switching      <= 1'b0;
         count_start    <= 1'b0;
      end else begin
         count_start <= 1'b0;
         if (!sw_enabled) begin
            switch_request <= 1'b0;
            switching      <= 1'b0;
         end else if (switching) begin
            if (fail_seen) begin
               switching      <= 1'b0;
               switch_request <= 1'b0;
            end else if (count_done) begin
               switching      <= 1'b0;
               switch_request <= 1'b0;
            end else if (src_ready && !armed) begin
               count_start <= 1'b1;
            end
         end else if (switch_request) begin
            if (current_source_status == next_source_select) begin
               switch_request <= 1'b0;
            end else begin
               switching <= 1'b1;
            end
         end else if (wr_ctrl && lo_open && reg_wdata[SWREQ_BIT]) begin
            switch_request <= 1'b1;
         end
      end
   end

   // Start handover count once the new source reports ready
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         armed <= 1'b0;
      end else if (!switching) begin
         armed <= 1'b0;
      end else if (src_ready && !armed) begin
         armed <= 1'b1;
      end
   end
   assign fail_seen = stat.osc_fail && sw_enabled && !in_sleep;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         current_source_status <= SRC_FRC;
      end else if (!sw_enabled) begin
         current_source_status <= initial_source_config;
      end else if (fail_seen) begin
         current_source_status <= csp_uses_pll(current_source_status) ?
                                  SRC_FRC_PLL : SRC_FRC;
      end else if (switching && count_done) begin
         current_source_status <= next_source_select;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         lock_flag       <= 1'b0;
         clock_fail_flag <= 1'b0;
         fail_trap       <= 1'b0;
      end else begin
         fail_trap <= fail_seen && !clock_fail_flag;
         if (fail_seen) begin
            clock_fail_flag <= 1'b1;
         end else if (switch_request && !switching &&
                      current_source_status != next_source_select) begin
            clock_fail_flag <= 1'b0;
         end
         if (switch_request && !switching &&
             current_source_status != next_source_select) begin
            lock_flag <= 1'b0;
         end else begin
            lock_flag <= stat.pll_lock;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-save entry, wake and clock gating

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         entering   <= 1'b0;
         entry_mode <= 1'b0;
         held_irq   <= 1'b0;
      end else if (psave_exec && !in_sleep && !in_idle) begin
         entering   <= 1'b1;
         entry_mode <= (psave_operand == PSAVE_IDLE);
         held_irq   <= irq_pending;
      end else begin
         entering <= 1'b0;
         if (!entering) begin
            held_irq <= 1'b0;
         end
      end
   end

   assign wake_event = irq_pending || held_irq || wdt_timeout;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         in_sleep <= 1'b0;
         in_idle  <= 1'b0;
      end else if (entering) begin
         in_sleep <= !entry_mode;
         in_idle  <= entry_mode;
      end else if (wake_event) begin
         in_sleep <= 1'b0;
         in_idle  <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         wake_cnt <= 3'h0;
      end else if (in_idle && wake_event && !entering) begin
         wake_cnt <= WAKE_CYCLES;
      end else if (wake_cnt != 3'h0) begin
         wake_cnt <= wake_cnt - 3'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         watchdog_clear <= 1'b0;
      end else begin
         watchdog_clear <= psave_exec && !in_sleep && !in_idle && watchdog_enable;
      end
   end

   assign cpu_clk_en    = !in_sleep && !in_idle && (wake_cnt == 3'h0) && !entering;
   assign periph_clk_en = !in_sleep;
   assign sys_clk_en    = !in_sleep;
   assign sys_src_sel   = current_source_status;

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator enables

   function automatic logic src_active(input logic [2:0] s, input logic [2:0] a,
                                       input logic [2:0] b);
      return (s == a) || (s == b);
   endfunction

   always_comb begin
      osc_en.pri_on    = !in_sleep &&
                         (src_active(current_source_status, SRC_PRI, SRC_PRI_PLL) ||
                          (switching && csp_is_crystal(next_source_select) &&
                           next_source_select != SRC_LPXTAL));
      osc_en.frc_on    = !in_sleep &&
                         (src_active(current_source_status, SRC_FRC, SRC_FRC_PLL) ||
                          (switching && src_active(next_source_select, SRC_FRC,
                                                   SRC_FRC_PLL)));
      osc_en.lpxtal_on = (current_source_status == SRC_LPXTAL && !in_sleep) ||
                         (switching && next_source_select == SRC_LPXTAL) ||
                         low_power_crystal_keep;
      osc_en.low_power_rc_osc_on   = (current_source_status == SRC_LOW_POWER_RC_OSC && !in_sleep) ||
                         (switching && next_source_select == SRC_LOW_POWER_RC_OSC) ||
                         watchdog_enable ||
                         (sw_enabled && !in_sleep);
      osc_en.pll_on    = !in_sleep && (csp_uses_pll(current_source_status) ||
                         (switching && csp_uses_pll(next_source_select)));
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register read port

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_OSC_CTRL: begin
               reg_rdata                     <= 16'h0000;
               reg_rdata[CUR_LSB +: 3]       <= current_source_status;
               reg_rdata[NEXT_LSB +: 3]      <= next_source_select;
               reg_rdata[LOCK_BIT]           <= lock_flag;
               reg_rdata[FAIL_BIT]           <= clock_fail_flag;
               reg_rdata[SWREQ_BIT]          <= switch_request && sw_enabled;
            end
            REG_PWR_STAT: reg_rdata <= {13'h0000, switching, in_idle, in_sleep};
            default:      reg_rdata <= 16'h0000;
         endcase
      end
   end

endmodule

/* src/csp_new_clk_count.sv */
`timescale 1ns/1ps
module csp_new_clk_count
   import csp_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic start,
   input  wire logic new_clk_tick,
   output logic      done
);

   logic [3:0] count;
   logic       run;

   // Counts edges of the incoming source, already synchronised
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         count <= 4'h0;
         run   <= 1'b0;
      end else if (start) begin
         count <= 4'h0;
         run   <= 1'b1;
      end else if (run && new_clk_tick) begin
         count <= count + 4'h1;
         if (count == HANDOVER_CYCLES - 4'h1) begin
            run <= 1'b0;
         end
      end
   end

   assign done = run && new_clk_tick && (count == HANDOVER_CYCLES - 4'h1);

endmodule

/* src/csp_pkg.sv */
package csp_pkg;

   // Oscillator source codes held in the source fields
   localparam logic [2:0] SRC_FRC      = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL  = 3'h1;
   localparam logic [2:0] SRC_PRI      = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL  = 3'h3;
   localparam logic [2:0] SRC_LPXTAL   = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC_OSC     = 3'h5;

   // Register offsets on the plain register port
   localparam logic [3:0] REG_OSC_CTRL = 4'h0;
   localparam logic [3:0] REG_OSC_KEY  = 4'h1;
   localparam logic [3:0] REG_PWR_STAT = 4'h2;

   // Control register field positions
   localparam int SWREQ_BIT  = 0;
   localparam int FAIL_BIT   = 3;
   localparam int LOCK_BIT   = 5;
   localparam int NEXT_LSB   = 8;
   localparam int CUR_LSB    = 12;

   // Unlock key pairs, upper and lower byte
   localparam logic [15:0] KEY_HI_1 = 16'h0078;
   localparam logic [15:0] KEY_HI_2 = 16'h009a;
   localparam logic [15:0] KEY_LO_1 = 16'h0046;
   localparam logic [15:0] KEY_LO_2 = 16'h0057;

   // Power-save instruction operands
   localparam logic [1:0] PSAVE_SLEEP = 2'h0;
   localparam logic [1:0] PSAVE_IDLE  = 2'h1;

   // Handover and wake timing
   localparam logic [3:0] HANDOVER_CYCLES = 4'ha;
   localparam logic [2:0] WAKE_CYCLES     = 3'h3;

   typedef struct packed {
      logic       pri_on;
      logic       frc_on;
      logic       lpxtal_on;
      logic       low_power_rc_osc_on;
      logic       pll_on;
   } csp_osc_en_s;

   typedef struct packed {
      logic       pri_ready;
      logic       lpxtal_ready;
      logic       pll_lock;
      logic       osc_fail;
   } csp_osc_stat_s;

   typedef enum logic [1:0] {
      CSP_LOCKED,
      CSP_KEY1,
      CSP_OPEN
   } csp_key_e;

   function automatic logic csp_uses_pll(input logic [2:0] src);
      return (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
   endfunction

   function automatic logic csp_is_crystal(input logic [2:0] src);
      return (src == SRC_PRI) || (src == SRC_PRI_PLL) || (src == SRC_LPXTAL);
   endfunction

endpackage

/* src/csp_unlock.sv */
`timescale 1ns/1ps
module csp_unlock
   import csp_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        key_wr,
   input  wire logic [15:0] key_data,
   input  wire logic        consume,
   input  wire logic [15:0] key_first,
   input  wire logic [15:0] key_second,
   output logic             open
);

   csp_key_e state;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state <= CSP_LOCKED;
      end else if (consume) begin
         state <= CSP_LOCKED;
      end else if (key_wr) begin
         case (state)
            CSP_LOCKED: state <= (key_data == key_first) ? CSP_KEY1 : CSP_LOCKED;
            CSP_KEY1:   state <= (key_data == key_second) ? CSP_OPEN : CSP_LOCKED;
            default:    state <= CSP_LOCKED;
         endcase
      end
   end

   assign open = (state == CSP_OPEN);

endmodule

/* testbench/clock_switch_power_save_bench.sv */
`timescale 1ns/1ps
module clock_switch_power_save_bench
   import csp_pkg::*;
;
   logic          core_clk;
   logic          resetn;
   logic [3:0]    reg_addr;
   logic [15:0]   reg_wdata;
   logic          reg_wr;
   logic          reg_rd;
   logic [15:0]   reg_rdata;
   logic          switch_monitor_config;
   logic [2:0]    initial_source_config;
   logic [1:0]    primary_submode_config;
   logic          low_power_crystal_keep;
   logic          watchdog_enable;
   csp_osc_stat_s osc_stat;
   logic          new_clk_tick;
   logic          psave_exec;
   logic [1:0]    psave_operand;
   logic          irq_pending;
   logic          wdt_timeout;
   logic          fail_cmd;
   csp_osc_en_s   osc_en;
   logic [2:0]    sys_src_sel;
   logic [1:0]    primary_submode;
   logic          fail_trap;
   logic          watchdog_clear;
   logic          cpu_clk_en;
   logic          periph_clk_en;
   logic          sys_clk_en;
   int            miscompares = 0;
   int            total_checks = 0;
   int            wd_cnt = 0;
   int            trap_cnt = 0;
   int            n;
   int            k;
   logic          run_ok;
   logic [15:0]   rv;
   logic [5:0]    rows [8];

   csp_clock_ctrl i_csp_clock_ctrl (
      .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .switch_monitor_config, .initial_source_config, .primary_submode_config,
      .low_power_crystal_keep, .watchdog_enable, .osc_stat, .new_clk_tick, .psave_exec,
      .psave_operand, .irq_pending, .wdt_timeout, .osc_en, .sys_src_sel, .primary_submode,
      .fail_trap, .watchdog_clear, .cpu_clk_en, .periph_clk_en, .sys_clk_en
   );
   csp_osc_model i_csp_osc_model (.core_clk, .osc_en, .fail_cmd, .osc_stat, .new_clk_tick);
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (watchdog_clear === 1'b1) wd_cnt <= wd_cnt + 1;
      if (fail_trap === 1'b1) trap_cnt <= trap_cnt + 1;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("Checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic wr(logic [3:0] a, logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(logic [3:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge core_clk);
   endtask
   task automatic req_switch(logic [2:0] s);
      wr(REG_OSC_KEY, KEY_HI_1);
      wr(REG_OSC_KEY, KEY_HI_2);
      wr(REG_OSC_CTRL, {5'h0, s, 8'h00});
      wr(REG_OSC_KEY, KEY_LO_1);
      wr(REG_OSC_KEY, KEY_LO_2);
      wr(REG_OSC_CTRL, {5'h0, s, 8'h01});
   endtask
   task automatic wait_src(logic [2:0] s, output int c);
      c = 0;
      run_ok = 1'b1;
      while (sys_src_sel !== s && c < 400) begin
         @(posedge core_clk);
         c++;
         if (cpu_clk_en !== 1'b1) run_ok = 1'b0;
      end
   endtask
   task automatic wait_high(ref logic s, output int c);
      c = 0;
      while (s !== 1'b1 && c < 400) begin
         @(posedge core_clk);
         c++;
      end
   endtask
   task automatic psave(logic [1:0] op);
      psave_operand <= op;
      psave_exec <= 1'b1;
      @(posedge core_clk);
      psave_exec <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic do_reset(logic cfg, logic [2:0] init);
      resetn <= 1'b0;
      switch_monitor_config <= cfg;
      initial_source_config <= init;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      finish_test();
   end
   initial begin
      {resetn, reg_wr, reg_rd, psave_exec, irq_pending, wdt_timeout, fail_cmd} = 7'h0;
      {reg_addr, reg_wdata, psave_operand} = 22'h0;
      {switch_monitor_config, low_power_crystal_keep, watchdog_enable} = 3'h5;
      initial_source_config = SRC_PRI;
      primary_submode_config = 2'h1;
      // Next source, then pri, pll, lp crystal enables; PLL modes never adjacent
      rows = '{{SRC_FRC, 3'h0}, {SRC_PRI, 3'h4}, {SRC_FRC, 3'h0}, {SRC_LPXTAL, 3'h1},
               {SRC_LOW_POWER_RC_OSC, 3'h0}, {SRC_FRC_PLL, 3'h2}, {SRC_FRC, 3'h0},
               {SRC_PRI_PLL, 3'h6}};
      do_reset(1'b1, SRC_PRI);
      rd(REG_OSC_CTRL, rv);
      check("locked source", rv[14:12], SRC_PRI);
      req_switch(SRC_LOW_POWER_RC_OSC);
      rd(REG_OSC_CTRL, rv);
      check("locked request", rv[SWREQ_BIT], 1'b0);
      fail_cmd <= 1'b1;
      repeat (40) @(posedge core_clk);
      fail_cmd <= 1'b0;
      check("locked select", sys_src_sel, SRC_PRI);
      check("locked trap", trap_cnt, 0);
      primary_submode_config <= 2'h2;
      do_reset(1'b0, SRC_FRC);
      foreach (rows[i]) begin
         req_switch(rows[i][5:3]);
         wait_src(rows[i][5:3], n);
         rd(REG_OSC_CTRL, rv);
         check("current source", rv[14:12], rows[i][5:3]);
         check("switch request", rv[SWREQ_BIT], 1'b0);
         check("pri enable", osc_en.pri_on, rows[i][2]);
         check("pll enable", osc_en.pll_on, rows[i][1]);
         check("lp crystal enable", osc_en.lpxtal_on, rows[i][0]);
         check("frc enable", osc_en.frc_on, rows[i][5:3] inside {SRC_FRC, SRC_FRC_PLL});
         check("submode", primary_submode, primary_submode_config);
         check("cpu runs", run_ok, 1'b1);
         if (i > 0) check("handover", n >= 20, 1'b1);
      end
      fail_cmd <= 1'b1;
      wait_src(SRC_FRC_PLL, n);
      fail_cmd <= 1'b0;
      check("fallback source", sys_src_sel, SRC_FRC_PLL);
      rd(REG_OSC_CTRL, rv);
      check("trap raised", trap_cnt > 0, 1'b1);
      check("fail flag", rv[FAIL_BIT], 1'b1);
      check("lock set", rv[LOCK_BIT], 1'b1);
      req_switch(SRC_FRC);
      rd(REG_OSC_CTRL, rv);
      check("fail cleared", rv[FAIL_BIT], 1'b0);
      check("lock cleared", rv[LOCK_BIT], 1'b0);
      check("request pending", rv[SWREQ_BIT], 1'b1);
      wait_src(SRC_FRC, n);
      // Unlocked-free control write and unmapped write must change nothing
      wr(REG_OSC_CTRL, {5'h0, SRC_LOW_POWER_RC_OSC, 8'h01});
      wr(4'h7, 16'hffff);
      repeat (40) @(posedge core_clk);
      check("refused write", sys_src_sel, SRC_FRC);
      k = wd_cnt;
      psave(PSAVE_SLEEP);
      check("sleep clock", sys_clk_en, 1'b0);
      check("sleep fast rc", osc_en.frc_on, 1'b0);
      check("sleep low rc", osc_en.low_power_rc_osc_on, 1'b1);
      check("sleep wdt clear", wd_cnt - k, 1);
      rd(REG_PWR_STAT, rv);
      check("sleep status", rv[0], 1'b1);
      irq_pending <= 1'b1;
      wait_high(sys_clk_en, n);
      check("sleep resume", sys_src_sel, SRC_FRC);
      irq_pending <= 1'b0;
      repeat (8) @(posedge core_clk);
      k = wd_cnt;
      psave(PSAVE_IDLE);
      check("idle cpu", cpu_clk_en, 1'b0);
      check("idle periph", periph_clk_en, 1'b1);
      check("idle sys", sys_clk_en, 1'b1);
      check("idle wdt clear", wd_cnt - k, 1);
      wdt_timeout <= 1'b1;
      wait_high(cpu_clk_en, n);
      check("idle wake delay", n >= 4 && n <= 6, 1'b1);
      wdt_timeout <= 1'b0;
      repeat (4) @(posedge core_clk);
      // Interrupt coincident with entry: enters first, then wakes
      psave_operand <= PSAVE_IDLE;
      psave_exec <= 1'b1;
      irq_pending <= 1'b1;
      @(posedge core_clk);
      psave_exec <= 1'b0;
      irq_pending <= 1'b0;
      run_ok = 1'b1;
      repeat (4) begin
         @(posedge core_clk);
         if (cpu_clk_en === 1'b0) run_ok = 1'b0;
      end
      check("held irq enters", run_ok, 1'b0);
      wait_high(cpu_clk_en, n);
      check("held irq wakes", n < 10, 1'b1);
      low_power_crystal_keep <= 1'b1;
      @(posedge core_clk);
      check("lp crystal kept", osc_en.lpxtal_on, 1'b1);
      finish_test();
   end
endmodule

/* testbench/csp_clock_ctrl_asserts.sv */
`timescale 1ns/1ps
module csp_checker
   import csp_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic [3:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        switch_monitor_config,
   input wire logic [2:0]  initial_source_config,
   input wire logic [1:0]  primary_submode_config,
   input wire logic        watchdog_enable,
   input wire logic        psave_exec,
   input wire logic [1:0]  psave_operand,
   input wire logic        irq_pending,
   input wire logic        wdt_timeout,
   input wire csp_osc_en_s osc_en,
   input wire logic [2:0]  sys_src_sel,
   input wire logic [1:0]  primary_submode,
   input wire logic        fail_trap,
   input wire logic        watchdog_clear,
   input wire logic        cpu_clk_en,
   input wire logic        periph_clk_en,
   input wire logic        sys_clk_en
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////
   sequence s_locked;
      switch_monitor_config && $past(switch_monitor_config) && $past(resetn);
   endsequence
   sequence s_sleep_cmd;
      psave_exec && psave_operand == PSAVE_SLEEP;
   endsequence
   sequence s_idle_cmd;
      psave_exec && psave_operand == PSAVE_IDLE;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   a_submode_fixed: assert property (primary_submode == primary_submode_config)
      else $error("primary submode differs from its configuration");
   a_locked_source: assert property (
      s_locked |-> sys_src_sel == $past(initial_source_config))
      else $error("locked source does not follow initial configuration");
   a_locked_request: assert property (
      s_locked ##0 ($past(reg_rd) && $past(reg_addr) == REG_OSC_CTRL)
      |-> !reg_rdata[SWREQ_BIT])
      else $error("switch request reads one while switching is locked");
   a_locked_trap: assert property (s_locked |-> !fail_trap)
      else $error("failure trap while monitor is disabled");
   a_trap_fallback: assert property (
      fail_trap |-> ##[0:40] (sys_src_sel == SRC_FRC || sys_src_sel == SRC_FRC_PLL))
      else $error("no fallback to fast RC after trap");
   a_sleep_entry: assert property (s_sleep_cmd |-> ##[1:3] !sys_clk_en)
      else $error("sleep command did not stop system clock");
   a_idle_entry: assert property (
      s_idle_cmd |-> ##[1:3] (!cpu_clk_en && sys_clk_en && periph_clk_en))
      else $error("idle command did not halt only the cpu");
   a_sleep_gated: assert property (
      !sys_clk_en |-> !cpu_clk_en && !periph_clk_en && !osc_en.frc_on && !osc_en.pri_on)
      else $error("clock or oscillator left running in sleep");
   a_sleep_low_power_rc_osc: assert property (!sys_clk_en |-> osc_en.low_power_rc_osc_on == watchdog_enable)
      else $error("low-power RC in sleep not tied to watchdog");
   a_monitor_low_power_rc_osc: assert property (
      sys_clk_en && !switch_monitor_config |-> osc_en.low_power_rc_osc_on)
      else $error("low-power RC off while monitor enabled");
   a_wdt_clear: assert property (
      psave_exec && watchdog_enable |-> ##[1:3] watchdog_clear)
      else $error("watchdog not cleared on power-save entry");
   a_sleep_wake: assert property (
      !sys_clk_en && (irq_pending || wdt_timeout) |-> ##[1:16] sys_clk_en)
      else $error("no wake from sleep");
   a_sleep_resume: assert property (!sys_clk_en |=> $stable(sys_src_sel))
      else $error("source changed across sleep");
endmodule

bind csp_clock_ctrl csp_checker i_csp_checker (
   .core_clk, .resetn, .reg_addr, .reg_rd, .reg_rdata, .switch_monitor_config,
   .initial_source_config, .primary_submode_config, .watchdog_enable, .psave_exec,
   .psave_operand, .irq_pending, .wdt_timeout, .osc_en, .sys_src_sel, .primary_submode,
   .fail_trap, .watchdog_clear, .cpu_clk_en, .periph_clk_en, .sys_clk_en
);

/* testbench/csp_osc_model.sv */
`timescale 1ns/1ps
module csp_osc_model
   import csp_pkg::*;
(
   input  wire logic        core_clk,
   input  wire csp_osc_en_s osc_en,
   input  wire logic        fail_cmd,
   output csp_osc_stat_s    osc_stat,
   output logic             new_clk_tick
);
   logic [3:0] pri_sr = 4'h0;
   logic [3:0] lpx_sr = 4'h0;
   logic [5:0] pll_sr = 6'h0;
   // Ready only after a run of enabled cycles, lost at once when stopped
   always_ff @(posedge core_clk) begin
      pri_sr <= {pri_sr[2:0], osc_en.pri_on};
      lpx_sr <= {lpx_sr[2:0], osc_en.lpxtal_on};
      pll_sr <= {pll_sr[4:0], osc_en.pll_on};
   end
   assign osc_stat = {&pri_sr, &lpx_sr, &pll_sr, fail_cmd};
   // New clock at half rate, still while every source is off
   initial new_clk_tick = 1'b0;
   always @(posedge core_clk) begin
      new_clk_tick <= (|osc_en) ? ~new_clk_tick : 1'b0;
   end
endmodule
